// file: inc/acoustic_header_codec_defines.vh
// Purpose: Constants for the acoustic packet header codec.
// Assumes: Byte 0 of the header is sent first, low field bits first.
// Notes: CRC polynomial and seed are free choices shared by both paths.
`ifndef ACOUSTIC_HEADER_CODEC_DEFINES_VH
`define ACOUSTIC_HEADER_CODEC_DEFINES_VH
`define HDR_BYTES 4'h8
`define HDR_LAST_IDX 3'h7
`define MSG_DATA 8'h00
`define MSG_RANGE_RESP 8'h80
`define MSG_RANGE_REQ 8'h81
`define MSG_STATUS 8'h82
`define NODE_MAX_ID 8'hfe
`define NODE_BROADCAST 8'hff
`define LEN_WIDTH 10
`define LEN_MAX_PLAIN 10'h100
`define FRAME_BYTES 8'hff
`define MOD_FSK_80 5'h00
`define MOD_PSK_5120 5'h01
`define MOD_PSK_2560 5'h02
`define MOD_PSK_1280 5'h03
`define MOD_PSK_640 5'h04
`define MOD_PSK_10240 5'h05
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define RESERVED_TX 8'h00
`endif

// file: hdl/hdr_fifo.v
// Purpose: Small synchronous FIFO for payload bytes.
// Assumes: One clock, writes and reads with valid and ready.
// Notes: Depth must be a power of two.
`timescale 1ns/1ps
module hdr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_reg;
    reg [AW:0] rd_reg;
    wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    wire empty = (wr_reg == rd_reg);
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem[rd_reg[AW-1:0]];
    always @(posedge i_clk) begin
        if (i_in_valid && !full) begin
            mem[wr_reg[AW-1:0]] <= i_in_data;
        end
    end
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else begin
            if (i_in_valid && !full) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (i_out_ready && !empty) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule // hdr_fifo

// file: hdl/acoustic_header_codec.v
// What this block does
// - Every packet starts with eight header bytes.
// - Byte 0 is the message type code.
// - Byte 1 is source node identifier.
// - Byte 2 is destination; 0xff broadcasts.
// - Byte 3 is Q8 transmit scale factor.
// - Descriptor is zero when no payload.
// - Byte 6 is reserved.
// - Byte 7 holds CRC over header.
// - Nonzero descriptor: payload follows with no gap.
// - Ten-bit length split over bytes 4 and 5.
// - Plain length never exceeds 256 bytes.
// - Byte 5 upper five bits select modulation.
// - Modulation codes zero to five defined.
// - Descriptor bit 10 flags streaming mode.
// - Streaming length counts 255-byte frames.
// - Device pads final partial streaming frame.
//
// Purpose: Builds and parses acoustic packet headers around a byte stream.
// Assumes: Modulator uses a valid/ready byte stream; demodulator bytes arrive with valid only, no ready.
// Notes: Payload passes through a FIFO on the transmit path.
`timescale 1ns/1ps
`include "acoustic_header_codec_defines.vh"
module acoustic_header_codec #(
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_tx_start,
    output wire o_tx_ready,
    input wire [7:0] i_msg_type,
    input wire [7:0] i_source_node_id,
    input wire [7:0] i_dest_node_id,
    input wire [7:0] i_tx_scale_factor,
    input wire i_has_payload,
    input wire [9:0] i_payload_len,
    input wire i_stream,
    input wire [4:0] i_modulation,
    output wire o_tx_len_error,
    input wire i_pay_valid,
    output wire o_pay_ready,
    input wire [7:0] i_pay_data,
    input wire i_pay_last,
    output reg o_mod_valid,
    input wire i_mod_ready,
    output reg [7:0] o_mod_data,
    input wire i_dem_valid,
    input wire [7:0] i_dem_data,
    output reg o_rx_hdr_valid,
    output reg o_rx_crc_error,
    output reg [7:0] o_rx_msg_type,
    output reg [7:0] o_rx_source_node_id,
    output reg [7:0] o_rx_dest_node_id,
    output reg o_rx_broadcast,
    output reg [7:0] o_rx_tx_scale_factor,
    output reg [9:0] o_rx_payload_len,
    output reg o_rx_stream,
    output reg [4:0] o_rx_modulation,
    output reg o_rx_pay_valid,
    output reg [7:0] o_rx_pay_data
);
    localparam ST_IDLE = 2'd0;
    localparam ST_HDR = 2'd1;
    localparam ST_PAY = 2'd2;
    localparam ST_PAD = 2'd3;

    function [7:0] crc_byte;
        input [7:0] crc;
        input [7:0] data;
        integer k;
        reg [7:0] c;
        begin
            c = crc ^ data;
            for (k = 0; k < 8; k = k + 1) begin
                c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
            end
            crc_byte = c;
        end
    endfunction

    reg [1:0] state_reg;
    reg [2:0] idx_reg;
    reg [63:0] hdr_reg;
    reg [9:0] frames_reg;
    reg [7:0] fbyte_reg;
    reg [8:0] bytes_reg;
    reg stream_reg;
    reg [9:0] len_reg;

    wire fifo_valid;
    wire fifo_ready;
    wire [7:0] fifo_data;
    wire fifo_in_ready;
    reg last_seen_reg;

    hdr_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(i_pay_valid && state_reg != ST_IDLE),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_pay_data),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_ready),
        .o_out_data(fifo_data)
    );
    assign o_pay_ready = fifo_in_ready && (state_reg != ST_IDLE);

    wire len_bad = i_has_payload && !i_stream && (i_payload_len > `LEN_MAX_PLAIN);
    assign o_tx_len_error = i_tx_start && len_bad;
    assign o_tx_ready = (state_reg == ST_IDLE);

    // Descriptor forced to zero when no payload follows.
    wire [15:0] desc = i_has_payload ?
        {i_modulation, i_stream, i_payload_len} : 16'h0000;
    wire [55:0] hdr_body = {`RESERVED_TX, desc, i_tx_scale_factor, i_dest_node_id,
        i_source_node_id, i_msg_type};

    wire beat = o_mod_valid && i_mod_ready;
    wire pay_take = (state_reg == ST_PAY) && (!o_mod_valid || i_mod_ready) && fifo_valid;
    assign fifo_ready = pay_take;
    // Output stage holds one byte; a new one is loaded when it empties.
    wire can_load = !o_mod_valid || i_mod_ready;
    wire pay_in_frame_done = stream_reg ? (fbyte_reg == `FRAME_BYTES - 8'h01) : 1'b0;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= ST_IDLE;
            idx_reg <= 3'h0;
            hdr_reg <= 64'h0000_0000_0000_0000;
            frames_reg <= 10'h000;
            fbyte_reg <= 8'h00;
            bytes_reg <= 9'h000;
            stream_reg <= 1'b0;
            len_reg <= 10'h000;
            last_seen_reg <= 1'b0;
            o_mod_valid <= 1'b0;
            o_mod_data <= 8'h00;
        end else begin
            if (beat) begin
                o_mod_valid <= 1'b0;
            end
            if (i_pay_valid && o_pay_ready && i_pay_last) begin
                last_seen_reg <= 1'b1;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (i_tx_start && !len_bad) begin
                        hdr_reg <= {crc_byte(crc_byte(crc_byte(crc_byte(crc_byte(
                            crc_byte(crc_byte(`CRC_INIT, hdr_body[7:0]), hdr_body[15:8]),
                            hdr_body[23:16]), hdr_body[31:24]), hdr_body[39:32]),
                            hdr_body[47:40]), hdr_body[55:48]), hdr_body};
                        idx_reg <= 3'h0;
                        stream_reg <= i_has_payload && i_stream;
                        len_reg <= i_has_payload ? i_payload_len : 10'h000;
                        frames_reg <= 10'h000;
                        fbyte_reg <= 8'h00;
                        bytes_reg <= 9'h000;
                        last_seen_reg <= 1'b0;
                        state_reg <= ST_HDR;
                    end
                end
                ST_HDR: begin
                    if (can_load) begin
                        o_mod_valid <= 1'b1;
                        o_mod_data <= hdr_reg[7:0];
                        hdr_reg <= {8'h00, hdr_reg[63:8]};
                        idx_reg <= idx_reg + 3'h1;
                        if (idx_reg == `HDR_LAST_IDX) begin
                            // Payload is queued at once behind the header.
                            state_reg <= (len_reg != 10'h000) ? ST_PAY : ST_IDLE;
                        end
                    end
                end
                ST_PAY: begin
                    if (pay_take) begin
                        o_mod_valid <= 1'b1;
                        o_mod_data <= fifo_data;
                        if (stream_reg) begin
                            fbyte_reg <= pay_in_frame_done ? 8'h00 : fbyte_reg + 8'h01;
                            if (pay_in_frame_done) begin
                                frames_reg <= frames_reg + 10'h001;
                                if (frames_reg + 10'h001 == len_reg) begin
                                    state_reg <= ST_IDLE;
                                end
                            end
                        end else begin
                            bytes_reg <= bytes_reg + 9'h001;
                            if ({1'b0, bytes_reg} + 10'h001 == len_reg) begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end else if (stream_reg && last_seen_reg
                            && !fifo_valid) begin
                        state_reg <= ST_PAD;
                    end
                end
                ST_PAD: begin
                    if (can_load) begin
                        o_mod_valid <= 1'b1;
                        o_mod_data <= 8'h00;
                        fbyte_reg <= pay_in_frame_done ? 8'h00 : fbyte_reg + 8'h01;
                        if (pay_in_frame_done) begin
                            frames_reg <= frames_reg + 10'h001;
                            state_reg <= (frames_reg + 10'h001 == len_reg) ? ST_IDLE : ST_PAD;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Receive side: parse header, check CRC, then pass payload bytes.
    reg [2:0] rx_idx_reg;
    reg [7:0] rx_crc_reg;
    reg [55:0] rx_hdr_reg;
    reg rx_pay_reg;
    reg rx_stream_reg;
    reg [9:0] rx_len_reg;
    reg [9:0] rx_frames_reg;
    reg [7:0] rx_fbyte_reg;
    wire rx_frame_end = rx_fbyte_reg == `FRAME_BYTES - 8'h01;
    wire [15:0] rx_desc = rx_hdr_reg[47:32];

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_idx_reg <= 3'h0;
            rx_crc_reg <= `CRC_INIT;
            rx_hdr_reg <= 56'h00_0000_0000_0000;
            rx_pay_reg <= 1'b0;
            rx_stream_reg <= 1'b0;
            rx_len_reg <= 10'h000;
            rx_frames_reg <= 10'h000;
            rx_fbyte_reg <= 8'h00;
            o_rx_hdr_valid <= 1'b0;
            o_rx_crc_error <= 1'b0;
            o_rx_msg_type <= 8'h00;
            o_rx_source_node_id <= 8'h00;
            o_rx_dest_node_id <= 8'h00;
            o_rx_broadcast <= 1'b0;
            o_rx_tx_scale_factor <= 8'h00;
            o_rx_payload_len <= 10'h000;
            o_rx_stream <= 1'b0;
            o_rx_modulation <= 5'h00;
            o_rx_pay_valid <= 1'b0;
            o_rx_pay_data <= 8'h00;
        end else begin
            o_rx_hdr_valid <= 1'b0;
            o_rx_crc_error <= 1'b0;
            o_rx_pay_valid <= 1'b0;
            if (i_dem_valid && rx_pay_reg) begin
                o_rx_pay_valid <= 1'b1;
                o_rx_pay_data <= i_dem_data;
                if (rx_stream_reg) begin
                    rx_fbyte_reg <= rx_frame_end ? 8'h00 : rx_fbyte_reg + 8'h01;
                    if (rx_frame_end) begin
                        rx_frames_reg <= rx_frames_reg + 10'h001;
                        rx_pay_reg <= (rx_frames_reg + 10'h001 != rx_len_reg);
                    end
                end else begin
                    rx_len_reg <= rx_len_reg - 10'h001;
                    rx_pay_reg <= (rx_len_reg != 10'h001);
                end
            end else if (i_dem_valid) begin
                rx_idx_reg <= rx_idx_reg + 3'h1;
                rx_crc_reg <= crc_byte(rx_crc_reg, i_dem_data);
                rx_hdr_reg <= {i_dem_data, rx_hdr_reg[55:8]};
                if (rx_idx_reg == `HDR_LAST_IDX) begin
                    rx_crc_reg <= `CRC_INIT;
                    if (rx_crc_reg != i_dem_data) begin
                        o_rx_crc_error <= 1'b1;
                    end else begin
                        o_rx_hdr_valid <= 1'b1;
                        o_rx_msg_type <= rx_hdr_reg[7:0];
                        o_rx_source_node_id <= rx_hdr_reg[15:8];
                        o_rx_dest_node_id <= rx_hdr_reg[23:16];
                        o_rx_broadcast <= rx_hdr_reg[23:16] == `NODE_BROADCAST;
                        o_rx_tx_scale_factor <= rx_hdr_reg[31:24];
                        o_rx_payload_len <= rx_desc[9:0];
                        o_rx_stream <= rx_desc[10];
                        o_rx_modulation <= rx_desc[15:11];
                        // Reserved byte rx_hdr_reg[55:48] is not used.
                        rx_stream_reg <= rx_desc[10];
                        rx_len_reg <= rx_desc[9:0];
                        rx_frames_reg <= 10'h000;
                        rx_fbyte_reg <= 8'h00;
                        rx_pay_reg <= rx_desc[9:0] != 10'h000;
                    end
                end
            end
        end
    end
endmodule // acoustic_header_codec

// file: tb/mod_loopback.sv
// Purpose: Modulator sink that echoes every accepted byte into the demodulator input.
// Assumes: Echo comes one cycle after acceptance, with no back-pressure.
// Notes: Slow mode drops ready every other cycle; corrupt flips bit 0 of the echo.
`timescale 1ns/1ps
module mod_loopback (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_slow,
    input wire logic i_corrupt,
    input wire logic i_mod_valid,
    input wire logic [7:0] i_mod_data,
    output logic o_mod_ready,
    output logic o_dem_valid,
    output logic [7:0] o_dem_data
);
    logic [7:0] seen [$];
    logic phase_reg;
    assign o_mod_ready = !i_slow || phase_reg;
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_reg <= 1'b0;
            o_dem_valid <= 1'b0;
            o_dem_data <= 8'h00;
        end else begin
            phase_reg <= !phase_reg;
            o_dem_valid <= i_mod_valid && o_mod_ready;
            if (i_mod_valid && o_mod_ready) begin
                seen.push_back(i_mod_data);
                o_dem_data <= i_mod_data ^ {7'h00, i_corrupt};
            end else begin
                o_dem_data <= ~o_dem_data;
            end
        end
    end
endmodule // mod_loopback

// file: tb/header_monitor.sv
// Purpose: Concurrent checks on the header codec ports.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Attached to every codec instance by bind.
`timescale 1ns/1ps
module header_monitor (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_tx_start,
    input wire o_tx_ready,
    input wire o_tx_len_error,
    input wire i_has_payload,
    input wire [9:0] i_payload_len,
    input wire i_stream,
    input wire o_pay_ready,
    input wire o_mod_valid,
    input wire i_mod_ready,
    input wire [7:0] o_mod_data,
    input wire i_dem_valid,
    input wire o_rx_hdr_valid,
    input wire o_rx_crc_error,
    input wire [7:0] o_rx_dest_node_id,
    input wire o_rx_broadcast
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_start_busy: assert property (i_tx_start && o_tx_ready && !o_tx_len_error
        |=> !o_tx_ready)
        else $error("start taken but ready stayed high");
    a_first_byte: assert property (i_tx_start && o_tx_ready && !o_tx_len_error
        |-> ##1 !o_mod_valid ##1 o_mod_valid)
        else $error("first header byte not two cycles after start");
    a_mod_hold: assert property (o_mod_valid && !i_mod_ready
        |=> o_mod_valid && $stable(o_mod_data))
        else $error("byte to modulator changed while stalled");
    a_len_refuse: assert property (i_tx_start && !i_stream && i_has_payload
        && i_payload_len > 10'h100 |-> o_tx_len_error)
        else $error("oversize plain length not flagged");
    a_len_ok: assert property (!i_stream && i_payload_len <= 10'h100 |-> !o_tx_len_error)
        else $error("legal length flagged");
    a_bcast_flag: assert property (o_rx_hdr_valid
        |-> o_rx_broadcast == (o_rx_dest_node_id == 8'hff))
        else $error("broadcast flag wrong");
    a_pulse_excl: assert property (!(o_rx_hdr_valid && o_rx_crc_error))
        else $error("good and bad header at once");
    a_hdr_after_byte: assert property (o_rx_hdr_valid |-> $past(i_dem_valid))
        else $error("header pulse without a byte before it");
    a_hdr_single: assert property (o_rx_hdr_valid |=> !o_rx_hdr_valid)
        else $error("header pulse longer than one cycle");
    a_pay_idle: assert property (o_tx_ready |-> !o_pay_ready)
        else $error("payload accepted while idle");
    a_crc_after_byte: assert property (o_rx_crc_error |-> $past(i_dem_valid))
        else $error("header error pulse without a byte before it");
endmodule // header_monitor
bind acoustic_header_codec header_monitor u_mon (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_tx_start(i_tx_start), .o_tx_ready(o_tx_ready), .o_tx_len_error(o_tx_len_error),
    .i_has_payload(i_has_payload), .i_payload_len(i_payload_len), .i_stream(i_stream),
    .o_pay_ready(o_pay_ready), .o_mod_valid(o_mod_valid), .i_mod_ready(i_mod_ready),
    .o_mod_data(o_mod_data), .i_dem_valid(i_dem_valid), .o_rx_hdr_valid(o_rx_hdr_valid),
    .o_rx_crc_error(o_rx_crc_error), .o_rx_dest_node_id(o_rx_dest_node_id),
    .o_rx_broadcast(o_rx_broadcast));

// file: tb/testbench.sv
// Purpose: Self-checking bench for the header codec with a loopback modulator.
// Assumes: Transmitted bytes return through the demodulator input.
// Notes: Table rows first, then refusal, streaming, CRC error and reset cases.
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [7:0] t, s, d, f; logic p, st; logic [9:0] l; logic [4:0] m;} row_t;
    logic i_clk, i_rst_b, i_tx_start, i_has_payload, i_stream, i_pay_valid, i_pay_last;
    logic slow, corrupt;
    logic [7:0] i_msg_type, i_source_node_id, i_dest_node_id, i_tx_scale_factor, i_pay_data;
    logic [9:0] i_payload_len;
    logic [4:0] i_modulation;
    wire o_tx_ready, o_tx_len_error, o_pay_ready, o_mod_valid, mod_ready, dem_valid;
    wire o_rx_hdr_valid, o_rx_crc_error, o_rx_broadcast, o_rx_stream, o_rx_pay_valid;
    wire [7:0] o_mod_data, dem_data, o_rx_msg_type, o_rx_source_node_id, o_rx_dest_node_id;
    wire [7:0] o_rx_tx_scale_factor, o_rx_pay_data;
    wire [9:0] o_rx_payload_len;
    wire [4:0] o_rx_modulation;
    int err_count = 0, n_tests = 0, hdr_cnt, crc_cnt, pay_cnt, cyc = 0, row_len;
    logic [7:0] pay_x;
    row_t rows [8] = '{
        '{8'h00, 8'h01, 8'h02, 8'h80, 1, 0, 10'h003, 5'h00},
        '{8'h80, 8'hfe, 8'hff, 8'h00, 0, 0, 10'h005, 5'h03},
        '{8'h81, 8'h10, 8'hff, 8'hff, 0, 0, 10'h000, 5'h05},
        '{8'h82, 8'h22, 8'h33, 8'h44, 1, 0, 10'h001, 5'h01},
        '{8'h00, 8'h05, 8'h06, 8'h07, 1, 0, 10'h002, 5'h02},
        '{8'h00, 8'h07, 8'h08, 8'h09, 1, 0, 10'h004, 5'h03},
        '{8'h00, 8'h0a, 8'h0b, 8'h0c, 1, 0, 10'h100, 5'h04},
        '{8'h00, 8'h0d, 8'h0e, 8'h0f, 1, 0, 10'h006, 5'h05}};
    acoustic_header_codec DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_tx_start(i_tx_start),
        .o_tx_ready(o_tx_ready), .i_msg_type(i_msg_type), .i_source_node_id(i_source_node_id),
        .i_dest_node_id(i_dest_node_id), .i_tx_scale_factor(i_tx_scale_factor),
        .i_has_payload(i_has_payload), .i_payload_len(i_payload_len), .i_stream(i_stream),
        .i_modulation(i_modulation), .o_tx_len_error(o_tx_len_error), .i_pay_valid(i_pay_valid),
        .o_pay_ready(o_pay_ready), .i_pay_data(i_pay_data), .i_pay_last(i_pay_last),
        .o_mod_valid(o_mod_valid), .i_mod_ready(mod_ready), .o_mod_data(o_mod_data),
        .i_dem_valid(dem_valid), .i_dem_data(dem_data), .o_rx_hdr_valid(o_rx_hdr_valid),
        .o_rx_crc_error(o_rx_crc_error), .o_rx_msg_type(o_rx_msg_type),
        .o_rx_source_node_id(o_rx_source_node_id), .o_rx_dest_node_id(o_rx_dest_node_id),
        .o_rx_broadcast(o_rx_broadcast), .o_rx_tx_scale_factor(o_rx_tx_scale_factor),
        .o_rx_payload_len(o_rx_payload_len), .o_rx_stream(o_rx_stream),
        .o_rx_modulation(o_rx_modulation), .o_rx_pay_valid(o_rx_pay_valid),
        .o_rx_pay_data(o_rx_pay_data));
    mod_loopback lb (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_slow(slow), .i_corrupt(corrupt),
        .i_mod_valid(o_mod_valid), .i_mod_data(o_mod_data), .o_mod_ready(mod_ready),
        .o_dem_valid(dem_valid), .o_dem_data(dem_data));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        hdr_cnt += o_rx_hdr_valid;
        crc_cnt += o_rx_crc_error;
        pay_cnt += o_rx_pay_valid;
        if (o_rx_pay_valid) pay_x ^= o_rx_pay_data;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int b = 0; b < 8; b++)
            r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
        return r;
    endfunction
    task automatic run_pkt(input row_t r, input int n_pay, input int n_exp, input bit bad);
        logic [7:0] h [8];
        logic [15:0] desc;
        logic [7:0] e, x;
        int k;
        desc = r.p ? {r.m, r.st, r.l} : 16'h0000;
        h = '{r.t, r.s, r.d, r.f, desc[7:0], desc[15:8], 8'h00, 8'h00};
        for (k = 0; k < 7; k++)
            h[7] = crc8(h[7], h[k]);
        do @(negedge i_clk); while (o_tx_ready !== 1'b1);
        lb.seen.delete();
        hdr_cnt = 0;
        crc_cnt = 0;
        pay_cnt = 0;
        pay_x = 8'h00;
        @(posedge i_clk);
        {i_msg_type, i_source_node_id, i_dest_node_id, i_tx_scale_factor} <= {r.t, r.s, r.d, r.f};
        {i_has_payload, i_stream, i_payload_len, i_modulation} <= {r.p, r.st, r.l, r.m};
        i_tx_start <= 1'b1;
        @(posedge i_clk);
        i_tx_start <= 1'b0;
        for (k = 0; k < n_pay; k++) begin
            i_pay_valid <= 1'b1;
            i_pay_data <= k[7:0] ^ 8'h5a;
            i_pay_last <= (k == n_pay - 1);
            do @(negedge i_clk); while (o_pay_ready !== 1'b1);
            @(posedge i_clk);
        end
        i_pay_valid <= 1'b0;
        i_pay_last <= 1'b0;
        for (k = 0; k < 3000 && lb.seen.size() < 8 + n_exp; k++)
            @(posedge i_clk);
        repeat (6) @(posedge i_clk);
        chk("byte count", 16'(8 + n_exp), 16'(lb.seen.size()));
        x = 8'h00;
        for (k = 0; k < 8 + n_exp; k++) begin
            e = k < 8 ? h[k] : (k - 8 < n_pay ? 8'((k - 8) ^ 8'h5a) : 8'h00);
            if (k >= 8) x ^= e;
            chk("sent byte", {8'h00, e}, {8'h00, lb.seen[k]});
        end
        chk("bad headers", bad ? 16'h0001 : 16'h0000, 16'(crc_cnt));
        chk("good headers", bad ? 16'h0000 : 16'h0001, 16'(hdr_cnt));
        if (!bad) begin
            chk("rx fields", {r.t, r.s}, {o_rx_msg_type, o_rx_source_node_id});
            chk("rx dest scale", {r.d, r.f},
                {o_rx_dest_node_id, o_rx_tx_scale_factor});
            chk("rx desc", desc, {o_rx_modulation, o_rx_stream, o_rx_payload_len});
            chk("rx bcast", {15'h0000, r.d == 8'hff}, {15'h0000, o_rx_broadcast});
            chk("rx pay count", 16'(n_exp), 16'(pay_cnt));
            chk("rx pay xor", {8'h00, x}, {8'h00, pay_x});
        end
    endtask
    initial begin
        {i_tx_start, i_has_payload, i_stream, i_pay_valid, i_pay_last, slow, corrupt} = 7'h00;
        {i_msg_type, i_source_node_id, i_dest_node_id, i_tx_scale_factor, i_pay_data} = 40'h0;
        i_payload_len = 10'h000;
        i_modulation = 5'h00;
        i_rst_b = 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            row_len = rows[i].p ? int'(rows[i].l) : 0;
            run_pkt(rows[i], row_len, row_len, 0);
            $display("row %0d done", i);
        end
        @(posedge i_clk);
        {i_has_payload, i_stream, i_payload_len} <= {1'b1, 1'b0, 10'h101};
        i_tx_start <= 1'b1;
        @(negedge i_clk);
        chk("length refused", 16'h0001, {15'h0000, o_tx_len_error});
        repeat (4) @(posedge i_clk);
        i_tx_start <= 1'b0;
        @(negedge i_clk);
        chk("refused start idle", 16'h0101, {7'h00, o_tx_ready, 7'h00, !o_mod_valid});
        $display("refusal done");
        slow <= 1'b1;
        run_pkt('{8'h00, 8'h31, 8'h32, 8'h33, 1, 1, 10'h001, 5'h02}, 3, 255, 0);
        slow <= 1'b0;
        $display("streaming done");
        corrupt <= 1'b1;
        run_pkt(rows[2], 0, 0, 1);
        corrupt <= 1'b0;
        $display("crc error done");
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        @(negedge i_clk);
        chk("reset outputs", 16'h0000,
            {12'h000, o_mod_valid, o_rx_hdr_valid, o_rx_crc_error, o_pay_ready});
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        run_pkt(rows[0], 3, 3, 0);
        $display("reset done");
        tally_and_finish();
    end
endmodule // testbench
